// ==== core/pfs_core.sv ====
// Frame selection, address matching and call packet reporting toward the host.
//
// Behaviour
// - search addresses only in frames marked selected; block info words are reported in any frame.
// - accept frame packets 20H-27H, 16 bits each.
// - range zero covers top frames, counting down.
// - frame selection bits reset to zero.
// - frame packet layout with zero byte 2.
// - assigned phase filters single-phase reception only.
// - report address only below three errors, enabled.
// - address packet id 01H with fixed layout.
// - phase field encodes A to D.
// - priority flag mirrors priority reception.
// - long address reports once, second index.
// - index 00H-0FH or 80H-8FH only.
// - tone-only sets flag, no vector follows.
// - word number gives vector position.
// - non-tone address always followed by vector.
// - vector packet id equals word position.
// - bad vector flags error, blocks messages.
// - four packet kinds reported to host.
// - only enabled slots take part in matching.
module pfs_core
  import pfs_pkg::*;
(
  // Clock and reset.
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  // Configuration packets from the host.
  input  wire logic                 cfg_valid_in,
  input  wire logic [PKT_W-1:0]     cfg_pkt_in,
  // Receiver control.
  input  wire logic                 dec_on_in,
  input  wire logic                 single_phase_in,
  input  wire logic [1:0]           assigned_phase_in,
  input  wire logic                 frame_start_in,
  input  wire logic [6:0]           frame_num_in,
  // Received words.
  input  wire pfs_rx_t              rx_in,
  output logic                      rx_ready_out,
  // Packets toward the host.
  output logic                      pkt_valid_out,
  input  wire logic                 pkt_ready_in,
  output logic [PKT_W-1:0]          pkt_data_out,
  // Status.
  output logic                      frame_active_out,
  output logic [PHASES-1:0]         msg_open_out
);
  default clocking chk_cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [SLOT_BITS-1:0] frame_sel_r    [RANGES];
  logic [SLOT_BITS-1:0] frame_sel_nxt  [RANGES];
  pfs_slot_t            slot_r         [SLOTS];
  pfs_slot_t            slot_nxt       [SLOTS];
  logic [SLOTS-1:0]     user_slot_enable_r;
  logic [SLOTS-1:0]     user_slot_enable_nxt;
  logic                 cfg_frame;
  logic                 cfg_enable;
  logic                 cfg_slot;

  always_comb begin
    cfg_frame  = cfg_valid_in && cfg_pkt_in[31:27] == ID_FRAME_HI && cfg_pkt_in[23:16] == 8'h00;
    cfg_enable = cfg_valid_in && cfg_pkt_in[31:24] == ID_ENABLE;
    cfg_slot   = cfg_valid_in && cfg_pkt_in[31:28] == ID_SLOT_HI && !cfg_pkt_in[23];
    frame_sel_nxt        = frame_sel_r;
    slot_nxt             = slot_r;
    user_slot_enable_nxt = user_slot_enable_r;
    if (cfg_frame) begin
      frame_sel_nxt[cfg_pkt_in[26:24]] = cfg_pkt_in[15:0];
    end
    if (cfg_enable) begin
      user_slot_enable_nxt = cfg_pkt_in[15:0];
    end
    if (cfg_slot) begin
      slot_nxt[cfg_pkt_in[27:24]] = cfg_pkt_in[22:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_sel_r        <= '{default: FRAME_SEL_RST};
      slot_r             <= '{default: '0};
      user_slot_enable_r <= ENABLE_RST;
    end else begin
      frame_sel_r        <= frame_sel_nxt;
      slot_r             <= slot_nxt;
      user_slot_enable_r <= user_slot_enable_nxt;
    end
  end

  // Range zero holds the highest sixteen frames, so the range is the inverted frame high bits.
  function automatic logic frame_selected(input logic [6:0] frame);
    logic [2:0] rng;
    rng = 3'h7 - frame[6:4];
    return frame_sel_r[rng][frame[3:0]];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Matching and packet building.

  pfs_state_t          state_r;
  pfs_state_t          state_nxt;
  logic [3:0]          long_idx_r;
  logic [3:0]          long_idx_nxt;
  logic [1:0]          long_phase_r;
  logic [1:0]          long_phase_nxt;
  logic [FRAMES-1:0]   pend_r      [PHASES];
  logic [FRAMES-1:0]   pend_nxt    [PHASES];
  logic [PHASES-1:0]   msg_open_r;
  logic [PHASES-1:0]   msg_open_nxt;
  logic                frame_active;
  logic                phase_ok;
  logic                take;
  logic                emit;
  logic [PKT_W-1:0]    pkt;
  logic [SLOTS-1:0]    hit;
  logic                hit_any;
  logic [3:0]          hit_idx;
  logic                addr_ok;
  logic                vec_err;
  logic [3:0]          second_idx;
  pfs_addr_pkt_t       apkt;
  pfs_vec_pkt_t        vpkt;
  logic                buf_full;

  always_comb begin
    frame_active = dec_on_in && frame_selected(frame_num_in);
    phase_ok     = !single_phase_in || rx_in.phase == assigned_phase_in;
    take         = rx_in.valid && !buf_full;
    hit          = '0;
    hit_any      = 1'b0;
    hit_idx      = 4'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      hit[i] = user_slot_enable_r[i] && slot_r[i].addr == rx_in.data;
      if (hit[i]) begin
        hit_any = 1'b1;
        hit_idx = 4'(i);
      end
    end
    second_idx = long_idx_r + 4'h1;
    addr_ok = take && rx_in.kind == KIND_ADDR && frame_active && phase_ok
              && rx_in.errs < ADDR_ERR_LIMIT;
    vec_err = rx_in.errs > VEC_ERR_MAX || rx_in.fail;
    apkt                 = '0;
    apkt.id              = ID_ADDR;
    apkt.priority_flag   = rx_in.prio;
    apkt.phase           = rx_in.phase;
    apkt.vector_word_pos = rx_in.vpos;
    vpkt        = '0;
    vpkt.id     = {1'b0, rx_in.pos};
    vpkt.err    = vec_err;
    vpkt.phase  = rx_in.phase;
    vpkt.vtype  = rx_in.data[18:16];
    vpkt.body   = rx_in.data[15:0];
    emit           = 1'b0;
    pkt            = '0;
    state_nxt      = state_r;
    long_idx_nxt   = long_idx_r;
    long_phase_nxt = long_phase_r;
    pend_nxt       = pend_r;
    msg_open_nxt   = msg_open_r;
    if (frame_start_in) begin
      pend_nxt     = '{default: '0};
      msg_open_nxt = '0;
    end
    if (take) begin
      case (rx_in.kind)
        KIND_BIW: begin
          emit = 1'b1;
          pkt  = {ID_BIW, 3'h0, rx_in.data};
        end
        KIND_ADDR: begin
          state_nxt = ST_IDLE;
          if (addr_ok && rx_in.temp_hit) begin
            apkt.match_index = IDX_TEMP_BASE | {4'h0, rx_in.temp_idx};
            emit             = 1'b1;
          end else if (addr_ok && state_r == ST_LONG && long_phase_r == rx_in.phase && hit[second_idx]) begin
            apkt.match_index    = {4'h0, second_idx};
            apkt.long_flag      = 1'b1;
            apkt.tone_only_flag = slot_r[second_idx].tone_only_flag;
            emit                = 1'b1;
          end else if (addr_ok && hit_any && slot_r[hit_idx].long_flag) begin
            // A long address in an even slot waits for its second word before anything is reported.
            if (!hit_idx[0]) begin
              state_nxt      = ST_LONG;
              long_idx_nxt   = hit_idx;
              long_phase_nxt = rx_in.phase;
            end
          end else if (addr_ok && hit_any) begin
            apkt.match_index    = {4'h0, hit_idx};
            apkt.tone_only_flag = slot_r[hit_idx].tone_only_flag;
            emit                = 1'b1;
          end
          if (emit) begin
            pkt = apkt;
            if (!apkt.tone_only_flag) begin
              pend_nxt[rx_in.phase][rx_in.vpos] = 1'b1;
            end
          end
        end
        KIND_VEC: begin
          if (pend_r[rx_in.phase][rx_in.pos]) begin
            emit = 1'b1;
            pkt  = vpkt;
            pend_nxt[rx_in.phase][rx_in.pos] = 1'b0;
            msg_open_nxt[rx_in.phase]        = !vec_err;
          end
        end
        KIND_MSG: begin
          if (msg_open_r[rx_in.phase]) begin
            emit = 1'b1;
            pkt  = {1'b0, rx_in.pos, 3'h0, rx_in.data};
          end
        end
        default: begin
          emit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r      <= ST_IDLE;
      long_idx_r   <= 4'h0;
      long_phase_r <= 2'h0;
      pend_r       <= '{default: '0};
      msg_open_r   <= '0;
    end else begin
      state_r      <= state_nxt;
      long_idx_r   <= long_idx_nxt;
      long_phase_r <= long_phase_nxt;
      pend_r       <= pend_nxt;
      msg_open_r   <= msg_open_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry packet buffer; a stalled host holds off the receiver through rx_ready_out.

  logic [PKT_W-1:0] buf_r   [BUF_DEPTH];
  logic [PKT_W-1:0] buf_nxt [BUF_DEPTH];
  logic             rd_r;
  logic             rd_nxt;
  logic [1:0]       cnt_r;
  logic [1:0]       cnt_nxt;
  logic             push;
  logic             pop;

  always_comb begin
    buf_full = cnt_r == 2'(BUF_DEPTH);
    push     = take && emit;
    pop      = cnt_r != 2'h0 && pkt_ready_in;
    buf_nxt  = buf_r;
    rd_nxt   = rd_r ^ pop;
    cnt_nxt  = cnt_r + 2'(push) - 2'(pop);
    if (push) begin
      buf_nxt[rd_r ^ cnt_r[0]] = pkt;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_r    <= '{default: '0};
      rd_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      buf_r    <= buf_nxt;
      rd_r     <= rd_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  assign rx_ready_out     = !buf_full;
  assign pkt_valid_out    = cnt_r != 2'h0;
  assign pkt_data_out     = buf_r[rd_r];
  assign frame_active_out = frame_active;
  assign msg_open_out     = msg_open_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_frame_gate;
    take && rx_in.kind == KIND_ADDR && !frame_active |-> !push;
  endproperty
  a_frame_gate: assert property (p_frame_gate) else $error("address reported in unselected frame");
  property p_range_store;
    cfg_frame |=> frame_sel_r[$past(cfg_pkt_in[26:24])] == $past(cfg_pkt_in[15:0]);
  endproperty
  a_range_store: assert property (p_range_store) else $error("frame packet not stored");
  property p_top_range;
    dec_on_in && frame_num_in == 7'h7F |-> frame_active == frame_sel_r[0][15];
  endproperty
  a_top_range: assert property (p_top_range) else $error("frame 127 not mapped to range 0 bit 15");
  property p_reset_clear;
    $rose(rst_n_in) |-> frame_sel_r[7] == FRAME_SEL_RST && user_slot_enable_r == ENABLE_RST;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("selection not clear after reset");
  property p_phase_filter;
    single_phase_in && rx_in.kind == KIND_ADDR && rx_in.phase != assigned_phase_in |-> !push;
  endproperty
  a_phase_filter: assert property (p_phase_filter) else $error("address on wrong phase reported");
  property p_addr_errs;
    push && rx_in.kind == KIND_ADDR |-> rx_in.errs < 3'h3 && pkt[31:24] == 8'h01;
  endproperty
  a_addr_errs: assert property (p_addr_errs) else $error("bad address packet reported");
  property p_index_range;
    push && rx_in.kind == KIND_ADDR |-> pkt[14:12] == 3'h0;
  endproperty
  a_index_range: assert property (p_index_range) else $error("address index out of range");
  property p_vector_pending;
    push && rx_in.kind == KIND_ADDR && !pkt[7] && !frame_start_in |=> pend_r[$past(rx_in.phase)][$past(rx_in.vpos)];
  endproperty
  a_vector_pending: assert property (p_vector_pending) else $error("vector not awaited after address");
  property p_vec_error;
    push && rx_in.kind == KIND_VEC && vec_err |-> pkt[23] ##1 !msg_open_r[$past(rx_in.phase)];
  endproperty
  a_vec_error: assert property (p_vec_error) else $error("messages open after bad vector");
  property p_msg_gate;
    take && rx_in.kind == KIND_MSG && !msg_open_r[rx_in.phase] |-> !push;
  endproperty
  a_msg_gate: assert property (p_msg_gate) else $error("message reported with gate shut");

  c_long: cover property (@(posedge mclk_in) disable iff (!rst_n_in) push && apkt.long_flag);
  c_vector: cover property (@(posedge mclk_in) disable iff (!rst_n_in) push && rx_in.kind == KIND_VEC);
  c_stall: cover property (@(posedge mclk_in) disable iff (!rst_n_in) rx_in.valid && buf_full);
endmodule

// ==== core/pfs_pkg.sv ====
// Shared constants and types for the frame-select and call-report block.
package pfs_pkg;
  localparam int FRAMES      = 128;
  localparam int SLOTS       = 16;
  localparam int SLOT_BITS   = 16;
  localparam int RANGES      = 8;
  localparam int PHASES      = 4;
  localparam int BUF_DEPTH   = 2;
  localparam int PKT_W       = 32;
  // Packet identifiers and identifier fields.
  localparam logic [7:0] ID_BIW        = 8'h00;
  localparam logic [7:0] ID_ADDR       = 8'h01;
  localparam logic [4:0] ID_FRAME_HI   = 5'h04;
  localparam logic [7:0] ID_ENABLE     = 8'h78;
  localparam logic [3:0] ID_SLOT_HI    = 4'h8;
  localparam logic [7:0] IDX_TEMP_BASE = 8'h80;
  // Error thresholds.
  localparam logic [2:0] ADDR_ERR_LIMIT = 3'h3;
  localparam logic [2:0] VEC_ERR_MAX    = 3'h2;
  // Reset values.
  localparam logic [15:0] FRAME_SEL_RST = 16'h0000;
  localparam logic [15:0] ENABLE_RST    = 16'h0000;

  typedef enum logic [1:0] {
    KIND_BIW  = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_VEC  = 2'h2,
    KIND_MSG  = 2'h3
  } pfs_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LONG = 2'b10
  } pfs_state_t;

  typedef struct packed {
    logic        valid;
    pfs_kind_t   kind;
    logic [6:0]  pos;
    logic [1:0]  phase;
    logic [20:0] data;
    logic [6:0]  vpos;
    logic [2:0]  errs;
    logic        prio;
    logic        fail;
    logic        temp_hit;
    logic [3:0]  temp_idx;
  } pfs_rx_t;

  typedef struct packed {
    logic        long_flag;
    logic        tone_only_flag;
    logic [20:0] addr;
  } pfs_slot_t;

  typedef struct packed {
    logic [7:0] id;
    logic       priority_flag;
    logic [1:0] phase;
    logic       long_flag;
    logic [3:0] unused;
    logic [7:0] match_index;
    logic       tone_only_flag;
    logic [6:0] vector_word_pos;
  } pfs_addr_pkt_t;

  typedef struct packed {
    logic [7:0]  id;
    logic        err;
    logic [1:0]  phase;
    logic [1:0]  unused;
    logic [2:0]  vtype;
    logic [15:0] body;
  } pfs_vec_pkt_t;
endpackage

// ==== tb/pager_frame_select_call_report_bench.sv ====
// Self-checking bench for frame selection and call packet reporting.
module pager_frame_select_call_report_bench;
  import pfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              mclk_in = 0, rst_n_in = 0, cfg_valid_in = 0, dec_on_in = 0;
  logic              single_phase_in = 0, frame_start_in = 0, stall = 0;
  logic [PKT_W-1:0]  cfg_pkt_in = '0;
  logic [1:0]        assigned_phase_in = '0;
  logic [6:0]        frame_num_in = '0;
  pfs_rx_t           rx_in = '0;
  logic              rx_ready_out, pkt_valid_out, pkt_ready_in, frame_active_out;
  logic [PKT_W-1:0]  pkt_data_out;
  logic [PHASES-1:0] msg_open_out;
  int                error_cnt = 0, checks = 0, cyc = 0;

  pfs_core uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cfg_valid_in(cfg_valid_in), .cfg_pkt_in(cfg_pkt_in),
    .dec_on_in(dec_on_in), .single_phase_in(single_phase_in), .assigned_phase_in(assigned_phase_in),
    .frame_start_in(frame_start_in), .frame_num_in(frame_num_in), .rx_in(rx_in), .rx_ready_out(rx_ready_out),
    .pkt_valid_out(pkt_valid_out), .pkt_ready_in(pkt_ready_in), .pkt_data_out(pkt_data_out),
    .frame_active_out(frame_active_out), .msg_open_out(msg_open_out));
  pfs_host host (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pkt_valid_in(pkt_valid_out),
    .pkt_data_in(pkt_data_out), .pkt_ready_out(pkt_ready_in), .stall_in(stall));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic cfg(input logic [31:0] p);
    cfg_pkt_in = p;
    cfg_valid_in = 1;
    tick(1);
    cfg_valid_in = 0;
    tick(1);
  endtask

  task automatic fs();
    frame_start_in = 1;
    tick(1);
    frame_start_in = 0;
    tick(1);
  endtask

  task automatic send(input pfs_rx_t w);
    int n;
    w.valid = 1'b1;
    rx_in = w;
    for (n = 0; n < 50 && rx_ready_out !== 1'b1; n++) tick(1);
    if (rx_ready_out !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t receiver never ready", $time);
    end
    tick(1);
    rx_in.valid = 0;
    tick(1);
  endtask

  task automatic got(input logic [31:0] e, input string m);
    int n;
    for (n = 0; n < 20 && host.q.size() == 0; n++) tick(1);
    if (host.q.size() == 0) chk('x, e, m);
    else chk(host.q.pop_front(), e, m);
  endtask

  task automatic none(input string m);
    tick(6);
    chk(host.q.size(), 0, m);
  endtask

  task automatic fa(input int f, input logic e);
    frame_num_in = f[6:0];
    tick(1);
    chk(frame_active_out, e, "frame active");
  endtask

  function automatic pfs_rx_t aw(input logic [20:0] a, input logic [1:0] ph, input logic [2:0] e,
                                 input logic pr, input logic [6:0] vp);
    aw = '0;
    aw.kind = KIND_ADDR;
    aw.data = a;
    aw.phase = ph;
    aw.errs = e;
    aw.prio = pr;
    aw.vpos = vp;
  endfunction

  function automatic pfs_rx_t ow(input pfs_kind_t k, input logic [6:0] p, input logic [1:0] ph, input logic f);
    ow = '0;
    ow.kind = k;
    ow.pos = p;
    ow.phase = ph;
    ow.fail = f;
    ow.data = 21'h03A5C3;
  endfunction

  function automatic logic [31:0] ap(input logic pr, input logic [1:0] ph, input logic lg, input logic [7:0] ix,
                                     input logic to, input logic [6:0] vp);
    return {ID_ADDR, pr, ph, lg, 4'h0, ix, to, vp};
  endfunction

  function automatic logic [31:0] vp(input logic [6:0] p, input logic e, input logic [1:0] ph);
    return {1'b0, p, e, ph, 2'b00, 3'h3, 16'hA5C3};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_frames();
    cfg(32'h2700_0001);
    dec_on_in = 1;
    for (int f = 0; f < FRAMES; f++) fa(f, f == 0);
    for (int r = 0; r < RANGES; r++) begin
      cfg({ID_FRAME_HI, r[2:0], 8'h00, 16'h8001});
      fa(127 - 16 * r, 1);
      fa(126 - 16 * r, 0);
      fa(112 - 16 * r, 1);
    end
    cfg(32'h2701_4000);
    fa(14, 0);
    cfg(32'h2700_0001);
    fa(15, 0);
    dec_on_in = 0;
    fa(0, 0);
    dec_on_in = 1;
    $display("test frames done");
  endtask

  task automatic t_addr();
    cfg({ID_SLOT_HI, 4'h0, 3'b001, 21'h0F0F0F});
    cfg({ID_SLOT_HI, 4'h2, 3'b000, 21'h123456});
    cfg({ID_SLOT_HI, 4'h3, 3'b000, 21'h1FFFFE});
    cfg({ID_SLOT_HI, 4'h4, 3'b010, 21'h055555});
    cfg({ID_SLOT_HI, 4'h5, 3'b010, 21'h0AAAAA});
    cfg({ID_SLOT_HI, 4'hF, 3'b000, 21'h000001});
    cfg(32'h7800_8035);
    fs();
    send(aw(21'h123456, 2'd1, 3'd2, 1'b1, 7'd87));
    got(ap(1, 1, 0, 8'h02, 0, 7'd87), "address packet");
    send(ow(KIND_VEC, 7'd87, 2'd1, 0));
    got(vp(7'd87, 0, 2'd1), "vector packet");
    chk(msg_open_out, 4'b0010, "message gate");
    send(ow(KIND_MSG, 7'd50, 2'd1, 0));
    got({1'b0, 7'd50, 3'b000, 21'h03A5C3}, "message packet");
    send(ow(KIND_BIW, 7'd1, 2'd0, 0));
    got({ID_BIW, 3'b000, 21'h03A5C3}, "block info packet");
    send(aw(21'h123456, 2'd0, 3'd3, 1'b0, 7'd9));
    none("three errors");
    send(aw(21'h1FFFFE, 2'd0, 3'd0, 1'b0, 7'd9));
    none("disabled slot");
    frame_num_in = 7'd1;
    send(aw(21'h123456, 2'd0, 3'd0, 1'b0, 7'd9));
    none("frame not selected");
    frame_num_in = 7'd0;
    send(aw(21'h123456, 2'd3, 3'd0, 1'b0, 7'd2));
    got(ap(0, 3, 0, 8'h02, 0, 7'd2), "address packet");
    send(ow(KIND_VEC, 7'd2, 2'd3, 1));
    got(vp(7'd2, 1, 2'd3), "bad vector");
    chk(msg_open_out[3], 0, "gate shut");
    send(ow(KIND_MSG, 7'd60, 2'd3, 0));
    none("message after bad vector");
    fs();
    chk(msg_open_out, 4'h0, "gates cleared");
    send(aw(21'h000001, 2'd0, 3'd0, 1'b0, 7'd3));
    got(ap(0, 0, 0, 8'h0F, 0, 7'd3), "top slot");
    fs();
    $display("test addr done");
  endtask

  task automatic t_tone();
    pfs_rx_t t;
    send(aw(21'h0F0F0F, 2'd2, 3'd0, 1'b0, 7'd0));
    got(ap(0, 2, 0, 8'h00, 1, 7'd0), "tone only");
    send(ow(KIND_VEC, 7'd0, 2'd2, 0));
    none("no vector for tone");
    send(aw(21'h055555, 2'd0, 3'd0, 1'b0, 7'd5));
    none("long first word");
    send(aw(21'h0AAAAA, 2'd0, 3'd0, 1'b0, 7'd5));
    got(ap(0, 0, 1, 8'h05, 0, 7'd5), "long second word");
    none("one packet for long");
    t = aw(21'h1F0000, 2'd0, 3'd0, 1'b0, 7'd6);
    t.temp_hit = 1'b1;
    t.temp_idx = 4'hF;
    send(t);
    got(ap(0, 0, 0, 8'h8F, 0, 7'd6), "temporary index");
    fs();
    $display("test tone long temp done");
  endtask

  task automatic t_phase();
    for (int p = 0; p < PHASES; p++) begin
      send(aw(21'h123456, p[1:0], 3'd0, 1'b0, 7'd7));
      got(ap(0, p[1:0], 0, 8'h02, 0, 7'd7), "phase field");
    end
    fs();
    single_phase_in = 1;
    assigned_phase_in = 2'd2;
    send(aw(21'h123456, 2'd1, 3'd0, 1'b0, 7'd7));
    none("other phase");
    send(aw(21'h123456, 2'd2, 3'd0, 1'b0, 7'd7));
    got(ap(0, 2, 0, 8'h02, 0, 7'd7), "assigned phase");
    single_phase_in = 0;
    fs();
    $display("test phase done");
  endtask

  task automatic t_buf();
    stall = 1;
    send(aw(21'h123456, 2'd0, 3'd0, 1'b0, 7'd11));
    send(aw(21'h123456, 2'd1, 3'd0, 1'b0, 7'd12));
    tick(3);
    chk({rx_ready_out, pkt_valid_out}, 2'b01, "buffer full");
    stall = 0;
    send(aw(21'h123456, 2'd2, 3'd0, 1'b0, 7'd13));
    for (int p = 0; p < 3; p++) got(ap(0, p[1:0], 0, 8'h02, 0, 7'd11 + p[6:0]), "drain order");
    fs();
    $display("test buffer done");
  endtask

  initial begin
    tick(10);
    rst_n_in = 1;
    tick(1);
    chk({pkt_valid_out, rx_ready_out, msg_open_out}, 6'b010000, "reset outputs");
    t_frames();
    t_addr();
    t_tone();
    t_phase();
    t_buf();
    summarize();
  end
endmodule

// ==== tb/pfs_host.sv ====
// Host model that takes call packets from the block, stalls on request and keeps them in order.
module pfs_host
  import pfs_pkg::*;
(
  // Clock and reset.
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // Packet stream from the block.
  input  wire logic             pkt_valid_in,
  input  wire logic [PKT_W-1:0] pkt_data_in,
  output logic                  pkt_ready_out,
  // Stall control from the bench.
  input  wire logic             stall_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PKT_W-1:0] q[$];

  assign pkt_ready_out = !stall_in;

  // A packet is taken at the edge where valid and ready are both high.
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q.delete();
    end else if (pkt_valid_in && pkt_ready_out && pkt_data_in[31:24] == ID_ADDR) begin
      q.push_back({pkt_data_in[31:20], 4'h0, pkt_data_in[15:0]});
    end else if (pkt_valid_in && pkt_ready_out) begin
      q.push_back(pkt_data_in);
    end
  end
endmodule
